// File: inc/rds_map.svh
// constants for the radio data status and control block
`ifndef RDS_MAP_SVH
`define RDS_MAP_SVH

// buffer sizes
`define RAM_DEPTH      5'd24
`define FIFO_DEPTH     4
`define BP_DEPTH       2'd2

// reset values of the control settings
`define LOSS_CRIT_RST  4'h2
`define ACQ_SEL_RST    1'b0
`define UNSYNC_WR_RST  1'b0
`define CORR_SET_RST   5'h12

// field positions inside the control words
`define LOSS_SEL_BIT   3
`define DEC_LSB        3

// uncorrectable status code and correction limits
`define CORR_UNFIX     3'h6
`define CORR_ILLEGAL   3'h2
`define SOFT_A_MAX     3'h1

// fill level tiers and next block threshold, counted in blocks
`define FILL_TIER1     5'd8
`define FILL_TIER2     5'd16
`define NEXT_AVAIL_MIN 5'd2

// output block framing: once only the last bit is unread the block is taken
`define CONSUME_SHIFTS 6'd30

`endif

// File: inc/rds_pkg.sv
// types shared by the radio data status and control block
package rds_pkg;

    // one decoded block as offered by the demodulator and syndrome stage
    typedef struct packed {
        logic [15:0] raw_word;
        logic [15:0] hard_word;
        logic [2:0]  hard_errs;
        logic [15:0] soft_word;
        logic [2:0]  soft_errs;
        logic        offset_found;
        logic [2:0]  offset_kind;
        logic        traffic;
    } rx_block_t;

    // one stored buffer entry
    typedef struct packed {
        logic [15:0] radio_data_word;
        logic        offset_found_flag;
        logic [2:0]  offset_kind_code;
        logic        traffic_subcarrier_flag;
        logic        block_synced_flag;
        logic [2:0]  corrected_bit_count;
    } ram_entry_t;

    // the 32-bit output block, first field leaves first
    typedef struct packed {
        logic [15:0] radio_data_word;
        logic        offset_found_flag;
        logic [2:0]  offset_kind_code;
        logic        next_block_avail_flag;
        logic [1:0]  fill_level_code;
        logic        traffic_subcarrier_flag;
        logic        block_synced_flag;
        logic [2:0]  corrected_bit_count;
        logic [3:0]  spare;
    } out_block_t;

    // decision mode, field order {bit4, bit3}
    typedef enum logic [1:0] {
        DEC_HARD   = 2'b00,
        DEC_SOFT_A = 2'b01,
        DEC_SOFT_B = 2'b10,
        DEC_BAD    = 2'b11
    } decision_t;

    typedef enum logic {
        ST_UNSYNC = 1'b0,
        ST_LOCKED = 1'b1
    } sync_state_t;

endpackage

// File: logic/block_fifo.sv
// small block staging fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module block_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         flush,
    // filling side
    input  wire logic         in_valid,
    output var  logic         in_ready_r,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign push      = in_valid & in_ready_r;
    assign pop       = out_valid & out_ready;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];

    // occupancy, ready is registered so the source sees a clean level
    always_comb begin
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clock) begin
        if (!nrst || flush) begin
            cnt_r      <= '0;
            wp_r       <= '0;
            rp_r       <= '0;
            in_ready_r <= 1'b0;
        end else begin
            cnt_r      <= cnt_nxt;
            in_ready_r <= (cnt_nxt < (AW+1)'(D));
            if (push) begin
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            end
        end
    end

    // storage needs no reset, only occupied slots are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

endmodule
`default_nettype wire

// File: logic/blk_corrector.sv
// picks the corrected word and its error status for one block
`timescale 1ns/1ps
`default_nettype none
module blk_corrector
    import rds_pkg::*;
(
    // decoded block and correction setting
    input  wire rds_pkg::rx_block_t blk,
    input  wire logic [4:0]         corr_set,
    // chosen result
    output logic [15:0]             fix_word,
    output logic [2:0]              fix_cnt
);
    `include "rds_map.svh"

    logic [2:0] limit;
    decision_t  mode;
    logic       use_soft;
    logic [2:0] errs;

    // correction limit, illegal settings fall back to the reset strength
    always_comb begin
        unique case ({corr_set[2], corr_set[1], corr_set[0]})
            3'h0:    limit = 3'h0;
            3'h1:    limit = 3'h1;
            3'h2:    limit = 3'h2;
            3'h3:    limit = 3'h3;
            3'h4:    limit = 3'h4;
            3'h5:    limit = 3'h5;
            default: limit = `CORR_ILLEGAL;
        endcase
    end

    // soft A only trusts single bit soft fixes, otherwise it takes the hard result and its count
    always_comb begin
        mode     = decision_t'(corr_set[`DEC_LSB+1:`DEC_LSB]);
        use_soft = (mode == DEC_SOFT_B) ||
                   ((mode == DEC_SOFT_A) && (blk.soft_errs <= `SOFT_A_MAX));
        errs     = use_soft ? blk.soft_errs : blk.hard_errs;
    end

    // over the limit: report uncorrectable and pass the raw bits through
    always_comb begin
        if (errs > limit) begin
            fix_cnt  = `CORR_UNFIX;
            fix_word = blk.raw_word;
        end else begin
            fix_cnt  = errs;
            fix_word = use_soft ? blk.soft_word : blk.hard_word;
        end
    end

endmodule
`default_nettype wire

// File: logic/rds_status_ctl.sv
// block sync, buffer writes and per-block status of the radio data decoder
`timescale 1ns/1ps
`default_nettype none
module rds_status_ctl
    import rds_pkg::*;
(
    // clock and reset
    input  wire logic               clock,
    input  wire logic               nrst,
    // decoded blocks from the demodulator
    input  wire logic               blk_valid,
    output var  logic               in_ready_r,
    input  wire rds_pkg::rx_block_t blk_data,
    // control settings
    input  wire logic [3:0]         loss_criteria,
    input  wire logic               acquire_rule_select,
    input  wire logic               sync_reset_ctl,
    input  wire logic               sync_reset_pin,
    input  wire logic               unsynced_write_ctl,
    input  wire logic [4:0]         correction_setting,
    // host read side
    input  wire logic               rd_start,
    input  wire logic               rd_shift,
    input  wire logic               rd_end,
    output var  rds_pkg::out_block_t out_block_r,
    output var  logic               out_bit_r,
    // present lock state
    output var  logic               sync_lock_r
);
    `include "rds_map.svh"

    ////////////////////////////////////////////////////////////////////
    // settings, registered so their reset values hold during reset
    logic [3:0]  loss_r;
    logic        acq_sel_r;
    logic        owe_r;
    logic [4:0]  corr_set_r;
    logic        sres_r;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            loss_r     <= `LOSS_CRIT_RST;
            acq_sel_r  <= `ACQ_SEL_RST;
            owe_r      <= `UNSYNC_WR_RST;
            corr_set_r <= `CORR_SET_RST;
            sres_r     <= 1'b0;
        end else begin
            loss_r     <= loss_criteria;
            acq_sel_r  <= acquire_rule_select;
            owe_r      <= unsynced_write_ctl;
            corr_set_r <= correction_setting;
            sres_r     <= sync_reset_ctl | sync_reset_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // staging fifo and correction choice
    logic       f_valid;
    logic       f_ready;
    rx_block_t  f_data;
    logic [15:0] fix_word;
    logic [2:0] fix_cnt;
    logic [1:0] pend_cnt_r;

    // stalls while a commit burst drains, so the source feels back-pressure
    assign f_ready = (pend_cnt_r == 2'd0) && !sres_r;

    block_fifo #(
        .W ($bits(rx_block_t)),
        .D (`FIFO_DEPTH)
    ) u_fifo (
        .clock      (clock),
        .nrst       (nrst),
        .flush      (sres_r),
        .in_valid   (blk_valid),
        .in_ready_r (in_ready_r),
        .in_data    (blk_data),
        .out_valid  (f_valid),
        .out_ready  (f_ready),
        .out_data   (f_data)
    );

    blk_corrector u_corr (
        .blk      (f_data),
        .corr_set (corr_set_r),
        .fix_word (fix_word),
        .fix_cnt  (fix_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // block synchronisation
    sync_state_t st_r;
    logic        h1_r;
    logic        h2_r;
    logic [4:0]  bad_cnt_r;
    logic [4:0]  loss_n;
    logic        accept;
    logic        hit;
    logic        bad;
    logic        acquire;
    logic        lose;
    logic        store_now;

    assign accept    = f_valid & f_ready;
    assign hit       = f_data.offset_found;
    assign bad       = loss_r[`LOSS_SEL_BIT] ? (fix_cnt == `CORR_UNFIX) : !hit;
    assign acquire   = (st_r == ST_UNSYNC) && hit && (h1_r || (!acq_sel_r && h2_r));
    assign lose      = (st_r == ST_LOCKED) && bad && ((bad_cnt_r + 5'd1) >= loss_n);
    assign store_now = (st_r == ST_LOCKED) || acquire || owe_r;

    // loss count field, index is {bit2, bit1, bit0}
    always_comb begin
        unique case ({loss_r[2], loss_r[1], loss_r[0]})
            3'h0: loss_n = 5'd3;
            3'h1: loss_n = 5'd4;
            3'h2: loss_n = 5'd5;
            3'h3: loss_n = 5'd6;
            3'h4: loss_n = 5'd8;
            3'h5: loss_n = 5'd10;
            3'h6: loss_n = 5'd12;
            3'h7: loss_n = 5'd16;
        endcase
    end

    // state moves once per accepted block; sync reset pins it unsynced
    always_ff @(posedge clock) begin
        if (!nrst || sres_r) begin
            st_r      <= ST_UNSYNC;
            h1_r      <= 1'b0;
            h2_r      <= 1'b0;
            bad_cnt_r <= 5'd0;
        end else if (accept) begin
            if (st_r == ST_LOCKED) begin
                if (lose) begin
                    st_r      <= ST_UNSYNC;
                    bad_cnt_r <= 5'd0;
                end else begin
                    bad_cnt_r <= bad ? bad_cnt_r + 5'd1 : 5'd0;
                end
                h1_r <= 1'b0;
                h2_r <= 1'b0;
            end else if (acquire) begin
                st_r <= ST_LOCKED;
                h1_r <= 1'b0;
                h2_r <= 1'b0;
            end else begin
                h2_r <= h1_r;
                h1_r <= hit;
            end
        end
    end

    // the pin shows the present state, not that of the block being read
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sync_lock_r <= 1'b0;
        end else begin
            sync_lock_r <= (st_r == ST_LOCKED);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // backward protection and commit queue
    ram_entry_t cur;
    ram_entry_t bp_r [2];
    logic [1:0] bp_cnt_r;
    ram_entry_t pend_r [3];
    logic [4:0] ram_cnt_r;
    logic       wr;

    always_comb begin
        cur.radio_data_word         = fix_word;
        cur.offset_found_flag       = hit;
        cur.offset_kind_code        = f_data.offset_kind;
        cur.traffic_subcarrier_flag = f_data.traffic;
        cur.block_synced_flag       = (st_r == ST_LOCKED);
        cur.corrected_bit_count     = fix_cnt;
    end

    // the last two unstored unsynced blocks are kept so acquisition can commit them too
    always_ff @(posedge clock) begin
        if (!nrst || sres_r) begin
            bp_cnt_r <= 2'd0;
        end else if (accept && !store_now) begin
            if (bp_cnt_r < `BP_DEPTH) begin
                bp_r[bp_cnt_r[0]] <= cur;
                bp_cnt_r          <= bp_cnt_r + 2'd1;
            end else begin
                bp_r[0] <= bp_r[1];
                bp_r[1] <= cur;
            end
        end else if (accept) begin
            bp_cnt_r <= 2'd0;
        end
    end

    assign wr = (pend_cnt_r != 2'd0) && (ram_cnt_r < `RAM_DEPTH);

    // protection blocks go ahead of the acquiring block, oldest first
    always_ff @(posedge clock) begin
        if (!nrst || sres_r) begin
            pend_cnt_r <= 2'd0;
        end else if (accept && store_now) begin
            pend_cnt_r <= bp_cnt_r + 2'd1;
            unique case (bp_cnt_r)
                2'd0: pend_r[0] <= cur;
                2'd1: begin
                    pend_r[0] <= bp_r[0];
                    pend_r[1] <= cur;
                end
                default: begin
                    pend_r[0] <= bp_r[0];
                    pend_r[1] <= bp_r[1];
                    pend_r[2] <= cur;
                end
            endcase
        end else if (wr) begin
            pend_r[0]  <= pend_r[1];
            pend_r[1]  <= pend_r[2];
            pend_cnt_r <= pend_cnt_r - 2'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // block buffer, read in arrival order
    ram_entry_t ram [24];
    logic [4:0] wp_r;
    logic [4:0] rp_r;
    logic       have_blk_r;
    logic [5:0] bit_cnt_r;
    logic       consume;
    out_block_t head;
    logic [31:0] sh_r;

    // a read cut with one bit left cannot be repeated, so it consumes too
    assign consume = rd_end && have_blk_r && (bit_cnt_r >= `CONSUME_SHIFTS);

    always_ff @(posedge clock) begin
        if (wr) begin
            ram[wp_r] <= pend_r[0];
        end
    end

    // stale blocks vanish on sync reset, so a new channel starts clean
    always_ff @(posedge clock) begin
        if (!nrst || sres_r) begin
            wp_r      <= 5'd0;
            rp_r      <= 5'd0;
            ram_cnt_r <= 5'd0;
        end else begin
            if (wr) begin
                wp_r <= (wp_r == `RAM_DEPTH - 5'd1) ? 5'd0 : wp_r + 5'd1;
            end
            if (consume) begin
                rp_r <= (rp_r == `RAM_DEPTH - 5'd1) ? 5'd0 : rp_r + 5'd1;
            end
            ram_cnt_r <= ram_cnt_r + {4'd0, wr} - {4'd0, consume};
        end
    end

    // head block with the fill status it carries when read
    always_comb begin
        head.radio_data_word         = ram[rp_r].radio_data_word;
        head.offset_found_flag       = ram[rp_r].offset_found_flag;
        head.offset_kind_code        = ram[rp_r].offset_kind_code;
        head.next_block_avail_flag   = (ram_cnt_r >= `NEXT_AVAIL_MIN);
        head.fill_level_code         = (ram_cnt_r >= `RAM_DEPTH)  ? 2'b11 :
                                       (ram_cnt_r >= `FILL_TIER2) ? 2'b10 :
                                       (ram_cnt_r >= `FILL_TIER1) ? 2'b01 : 2'b00;
        head.traffic_subcarrier_flag = ram[rp_r].traffic_subcarrier_flag;
        head.block_synced_flag       = ram[rp_r].block_synced_flag;
        head.corrected_bit_count     = ram[rp_r].corrected_bit_count;
        head.spare                   = 4'h0;
    end

    // serial read: latch on start, one bit per shift, consume on a full read
    always_ff @(posedge clock) begin
        if (!nrst || sres_r) begin
            out_block_r <= '0;
            out_bit_r   <= 1'b0;
            sh_r        <= 32'h0000_0000;
            bit_cnt_r   <= 6'd0;
            have_blk_r  <= 1'b0;
        end else if (rd_start) begin
            out_block_r <= (ram_cnt_r != 5'd0) ? head : '0;
            sh_r        <= (ram_cnt_r != 5'd0) ? head : 32'h0000_0000;
            out_bit_r   <= (ram_cnt_r != 5'd0) ? head[31] : 1'b0;
            have_blk_r  <= (ram_cnt_r != 5'd0);
            bit_cnt_r   <= 6'd0;
        end else if (rd_shift) begin
            sh_r      <= {sh_r[30:0], 1'b0};
            out_bit_r <= sh_r[30];
            if (bit_cnt_r != 6'h3F) begin
                bit_cnt_r <= bit_cnt_r + 6'd1;
            end
        end else if (rd_end) begin
            have_blk_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_read_empty;
        rd_start && (ram_cnt_r == 5'd0) && !sres_r;
    endsequence

    a_kind_legal: assert property (out_block_r.offset_kind_code[2:1] != 2'b11)
        else $error("offset kind code out of range");
    a_count_legal: assert property (out_block_r.corrected_bit_count != 3'h7)
        else $error("corrected count shows unused code");
    a_empty_zero: assert property (s_read_empty |=> (out_block_r == '0) && !out_bit_r)
        else $error("empty buffer did not read as zero");
    a_fill_full: assert property (rd_start && !sres_r && (ram_cnt_r == 5'd24)
                                  |=> out_block_r.fill_level_code == 2'b11)
        else $error("full buffer not coded as 11");
    a_next_avail: assert property (rd_start && !sres_r |=>
                                   out_block_r.next_block_avail_flag == ($past(ram_cnt_r) > 5'd1))
        else $error("next block flag wrong");
    a_reset_hold: assert property (sres_r ##1 sres_r |=> !sync_lock_r)
        else $error("lock shown during sync reset");
    a_abort_keep: assert property (rd_end && (bit_cnt_r < `CONSUME_SHIFTS) && !sres_r
                                   |=> rp_r == $past(rp_r))
        else $error("aborted read consumed its block");
    a_loss_declare: assert property (accept && lose |=> st_r == ST_UNSYNC ##1 sync_lock_r == 1'b0)
        else $error("sync not lost after bad run");
    a_uncorr_raw: assert property (f_valid && (fix_cnt == `CORR_UNFIX)
                                   |-> fix_word == f_data.raw_word)
        else $error("uncorrectable block altered");
    a_unsync_skip: assert property (accept && !store_now && !sres_r |=> pend_cnt_r == 2'd0)
        else $error("unsynced block queued for storage");

endmodule
`default_nettype wire

// File: sim/host_reader.sv
// host model that reads 32-bit output blocks one bit at a time
`timescale 1ns/1ps
`default_nettype none
module host_reader
    import rds_pkg::*;
(
    // clock
    input  wire logic                clock,
    // read strobes
    output var  logic                rd_start,
    output var  logic                rd_shift,
    output var  logic                rd_end,
    // returned block and serial bit
    input  wire rds_pkg::out_block_t out_block_r,
    input  wire logic                out_bit_r
);
    int bit_errs = 0;

    // strobes idle low from time zero
    initial begin
        rd_start = 1'b0;
        rd_shift = 1'b0;
        rd_end   = 1'b0;
    end

    // latch, take n further bits MSB first, then end; n below 30 aborts,
    // 30 leaves only the last bit and still consumes the block
    task automatic read_block(input int n, output out_block_t blk);
        int i;
        @(posedge clock);
        #1 rd_start = 1'b1;
        @(posedge clock);
        #1 rd_start = 1'b0;
        blk = out_block_r;
        if (out_bit_r !== blk[31]) bit_errs++;
        for (i = 30; i > 30 - n; i--) begin
            rd_shift = 1'b1;
            @(posedge clock);
            #1;
            if (out_bit_r !== blk[i]) bit_errs++;
        end
        rd_shift = 1'b0;
        rd_end = 1'b1;
        @(posedge clock);
        #1 rd_end = 1'b0;
        // one more idle edge; the consumed block already left the count on the rd_end edge
        @(posedge clock);
        #1;
    endtask
endmodule
`default_nettype wire

// File: sim/rds_status_ctl_bench.sv
// self-checking bench for the radio data status and control block
`timescale 1ns/1ps
`default_nettype none
module rds_status_ctl_bench
    import rds_pkg::*;
;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    logic       blk_valid = 1'b0;
    logic       in_ready_r;
    rx_block_t  blk_data = '0;
    // control inputs carry no reserved positions, all bits are meaningful
    logic [3:0] loss_criteria = 4'h2;
    logic       acq_sel = 1'b0;
    logic       sr_ctl = 1'b0;
    logic       sr_pin = 1'b0;
    logic       unsync_wr = 1'b0;
    logic [4:0] corr_set = 5'h02;
    logic       rd_start;
    logic       rd_shift;
    logic       rd_end;
    out_block_t out_blk;
    out_block_t got;
    logic       out_bit;
    logic       lock;
    int         err_total = 0;
    int         checked = 0;
    int         cycles = 0;

    // 50 MHz clock
    always #10 clock = ~clock;

    rds_status_ctl uut (.clock(clock), .nrst(nrst), .blk_valid(blk_valid),
        .in_ready_r(in_ready_r), .blk_data(blk_data), .loss_criteria(loss_criteria),
        .acquire_rule_select(acq_sel), .sync_reset_ctl(sr_ctl), .sync_reset_pin(sr_pin),
        .unsynced_write_ctl(unsync_wr), .correction_setting(corr_set),
        .rd_start(rd_start), .rd_shift(rd_shift), .rd_end(rd_end),
        .out_block_r(out_blk), .out_bit_r(out_bit), .sync_lock_r(lock));

    host_reader host (.clock(clock), .rd_start(rd_start), .rd_shift(rd_shift),
        .rd_end(rd_end), .out_block_r(out_blk), .out_bit_r(out_bit));

    // offer one block and hold it until the fifo takes it
    task automatic offer(input rx_block_t b);
        blk_data = b;
        blk_valid = 1'b1;
        @(posedge clock);
        while (in_ready_r !== 1'b1) @(posedge clock);
        #1;
    endtask

    // raw word differs from the fixed one by the error count
    task automatic send(input logic [15:0] w, input logic [2:0] e, input logic hit, input int k);
        rx_block_t b;
        b = '{w ^ {13'h0, e}, w, e, w, e, hit, 3'(k % 6), k[0]};
        offer(b);
    endtask

    task automatic idle(input int n);
        blk_valid = 1'b0;
        repeat (n) @(posedge clock);
        #1;
    endtask

    // expected clean block k with n blocks left including itself;
    // fill code is only trusted together with the next flag
    function automatic out_block_t good(input int k, input int n);
        return '{16'h1000 + 16'(k), 1'b1, 3'(k % 6), n > 1,
            n > 23 ? 2'h3 : n > 15 ? 2'h2 : n > 7 ? 2'h1 : 2'h0, k[0], k > 1, 3'h0, 4'h0};
    endfunction

    task automatic t_acquire;
        int k;
        host.read_block(31, got);
        `CHK(got, 32'h0)
        acq_sel = 1'b1;
        for (k = 0; k < 24; k++) send(16'h1000 + 16'(k), 3'h0, 1'b1, k);
        idle(10);
        `CHK(lock, 1'b1)
        host.read_block(5, got);
        for (k = 0; k < 24; k++) begin
            host.read_block(k == 23 ? 30 : 31, got);
            `CHK(got, good(k, 24 - k))
        end
        host.read_block(31, got);
        `CHK(got, 32'h0)
    endtask

    // limit of 2 in hard mode, then detection only; validity by count
    task automatic t_errors;
        send(16'h2222, 3'h3, 1'b1, 0);
        send(16'h3333, 3'h2, 1'b0, 1);
        idle(6);
        corr_set = 5'h00;
        send(16'h4444, 3'h1, 1'b1, 2);
        idle(6);
        host.read_block(31, got);
        `CHK(got, 32'h2221_88E0)
        host.read_block(31, got);
        `CHK(got, 32'h3333_19A0)
        host.read_block(31, got);
        `CHK(got, 32'h4445_A0E0)
    endtask

    // soft A keeps only single bit soft fixes, soft B takes them all
    task automatic t_soft;
        rx_block_t b;
        corr_set = 5'h0A;
        b = '{16'h7A00, 16'h7B00, 3'h3, 16'h7C00, 3'h1, 1'b1, 3'h0, 1'b0};
        offer(b);
        b = '{16'h7A01, 16'h7B01, 3'h1, 16'h7C01, 3'h2, 1'b1, 3'h0, 1'b0};
        offer(b);
        idle(4);
        corr_set = 5'h12;
        b = '{16'h7A02, 16'h7B02, 3'h1, 16'h7C02, 3'h2, 1'b1, 3'h0, 1'b0};
        offer(b);
        idle(6);
        host.read_block(31, got);
        `CHK({got.radio_data_word, got.corrected_bit_count}, {16'h7C00, 3'h1})
        host.read_block(31, got);
        `CHK({got.radio_data_word, got.corrected_bit_count}, {16'h7B01, 3'h1})
        host.read_block(31, got);
        `CHK({got.radio_data_word, got.corrected_bit_count}, {16'h7C02, 3'h2})
    endtask

    // three blocks without offset lose lock with field 000, then after
    // reacquiring, three uncorrectable blocks with the criterion select set
    task automatic t_loss;
        loss_criteria = 4'h0;
        send(16'h5000, 3'h0, 1'b0, 0);
        send(16'h5001, 3'h0, 1'b0, 1);
        idle(6);
        `CHK(lock, 1'b1)
        send(16'h5002, 3'h0, 1'b0, 2);
        idle(6);
        `CHK(lock, 1'b0)
        send(16'h5003, 3'h0, 1'b1, 3);
        send(16'h5004, 3'h0, 1'b1, 4);
        idle(6);
        `CHK(lock, 1'b1)
        loss_criteria = 4'h8;
        send(16'h5005, 3'h7, 1'b1, 5);
        send(16'h5006, 3'h7, 1'b1, 0);
        idle(6);
        `CHK(lock, 1'b1)
        send(16'h5007, 3'h7, 1'b1, 1);
        idle(6);
        `CHK(lock, 1'b0)
    endtask

    // new channel: lock first, then a pin reset with the control bit low,
    // later a control bit reset with the pin low
    task automatic t_sync_reset;
        send(16'h6100, 3'h0, 1'b1, 0);
        send(16'h6101, 3'h0, 1'b1, 1);
        idle(6);
        `CHK(lock, 1'b1)
        sr_pin = 1'b1;
        idle(4);
        `CHK(lock, 1'b0)
        sr_pin = 1'b0;
        acq_sel = 1'b0;
        idle(2);
        send(16'h6000, 3'h0, 1'b0, 0);
        idle(6);
        host.read_block(31, got);
        `CHK(got, 32'h0)
        send(16'h6001, 3'h0, 1'b1, 1);
        send(16'h6002, 3'h0, 1'b0, 2);
        send(16'h6003, 3'h0, 1'b1, 3);
        idle(10);
        `CHK(lock, 1'b1)
        host.read_block(31, got);
        `CHK(got.radio_data_word, 16'h6001)
        `CHK(got.next_block_avail_flag, 1'b1)
        sr_ctl = 1'b1;
        idle(4);
        `CHK(lock, 1'b0)
        sr_ctl = 1'b0;
        idle(2);
        host.read_block(31, got);
        `CHK(got, 32'h0)
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, far above the roughly 1500 cycles of the run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // reset for 10 cycles, then the scenarios
    initial begin
        repeat (10) @(posedge clock);
        #1 nrst = 1'b1;
        idle(2);
        t_acquire();
        t_errors();
        t_soft();
        t_loss();
        t_sync_reset();
        `CHK(host.bit_errs, 0)
        finish_test();
    end
endmodule
`default_nettype wire
